// ==== shared/pwmu_pkg.sv ====
package pwmu_pkg;

   // Geometry of the match bank and the modulated outputs
   localparam int unsigned NMATCH = 7;
   localparam int unsigned NOUT   = 6;
   localparam int unsigned ADDR_W = 12;

   // Register byte offsets
   localparam logic [7:0] OFS_ISR     = 8'h00;
   localparam logic [7:0] OFS_CTRL    = 8'h04;
   localparam logic [7:0] OFS_COUNT   = 8'h08;
   localparam logic [7:0] OFS_PRESC   = 8'h0c;
   localparam logic [7:0] OFS_PCNT    = 8'h10;
   localparam logic [7:0] OFS_MACT    = 8'h14;
   localparam logic [7:0] OFS_MATCH0  = 8'h18;
   localparam logic [7:0] OFS_MODE    = 8'h34;
   localparam logic [7:0] OFS_OUTCFG  = 8'h38;
   localparam logic [7:0] OFS_RELEASE = 8'h3c;
   localparam logic [7:0] OFS_IMASK   = 8'h40;

   // Control register bits
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam int unsigned CTRL_RST_BIT = 1;
   localparam int unsigned CTRL_PWM_BIT = 3;
   localparam int unsigned CTRL_W       = 4;

   // Mode register fields
   localparam int unsigned MODE_SEL_LSB = 0;
   localparam int unsigned MODE_CAP_BIT = 2;
   localparam int unsigned MODE_W       = 3;

   // Output config fields: double-edge selects and output enables
   localparam int unsigned OCFG_DBL_LSB = 0;
   localparam int unsigned OCFG_OE_LSB  = 8;
   localparam int unsigned OCFG_W       = 14;

   // Match action field width, three bits per match register
   localparam int unsigned MACT_W = 3;

   // Reset value shared by every register
   localparam logic [31:0] RST_WORD = 32'h0;

   // Count source selection
   typedef enum logic [1:0] {CNT_TIMER, CNT_RISE, CNT_FALL, CNT_BOTH} pwmu_cmode_t;

   // Per-match action set
   typedef struct packed {
      logic stop;
      logic rst;
      logic irq;
   } pwmu_mact_t;

   // One bus request as seen by the register file
   typedef struct packed {
      logic [7:0]  addr;
      logic        wr;
      logic [31:0] wdata;
   } pwmu_req_t;

endpackage

// ==== logic/pwmu_outgen.sv ====
`timescale 1ns/100ps
`default_nettype none

module pwmu_outgen
   import pwmu_pkg::*;
#(
   parameter int unsigned N_OUT = NOUT
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             pwm_en,
   input  wire logic [N_OUT-1:0] dbl,
   input  wire logic [N_OUT-1:0] oe,
   input  wire logic             cyc_start,
   input  wire logic [N_OUT:0]   hit,
   output logic      [N_OUT-1:0] pwm_out
);

   logic [N_OUT-1:0] out_r;
   logic [N_OUT-1:0] out_nxt;

   // Output k rises on the period match or on match k-1, falls on match k
   always_comb
   begin
      out_nxt = out_r;
      for (int j = 0; j < N_OUT; j++)
      begin
         logic set_e;
         set_e = (dbl[j] && j != 0) ? hit[j] : cyc_start;
         if (!pwm_en || !oe[j])
            out_nxt[j] = 1'b0;
         else if (hit[j+1])
            out_nxt[j] = 1'b0;
         else if (set_e)
            out_nxt[j] = 1'b1;
      end
   end

   // Falling wins a tie so a zero-width pulse stays low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_r <= '0;
      else
         out_r <= out_nxt;
   end

   assign pwm_out = out_r;

endmodule

`default_nettype wire

// ==== logic/pwmu_top.sv ====
`timescale 1ns/100ps
`default_nettype none

// Function
// - 32-bit counter stepped by 32-bit prescaler
// - Count clock cycles or capture input edges
// - Seven match registers feed six outputs
// - Match may continue, stop, reset, interrupt
// - With modulation, match zero resets counter, starts cycle
// - Single-edge outputs rise at cycle start
// - Single-edge falling edge from own match
// - Double-edge uses two matches, rise/fall
// - Either double edge anywhere in cycle
// - Edge order selects positive or negative pulse
// - One shared period, any count widths
// - Modulation match values apply only once released
// - Without modulation it is a plain timer
module pwmu_top
   import pwmu_pkg::*;
#(
   parameter int unsigned N_MATCH = NMATCH
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [1:0]        cap_in,
   output logic      [NOUT-1:0]   pwm_out,
   output logic                   irq
);

   // Address decode helpers, used by both the read and write paths, then the match action field picker
   function automatic logic upper_ok(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:8] == '0;
   endfunction

   function automatic logic is_mr(input logic [7:0] a);
      return (a >= OFS_MATCH0) && (a < OFS_MATCH0 + 8'(4 * N_MATCH)) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [2:0] mr_idx(input logic [7:0] a);
      return 3'((a - OFS_MATCH0) >> 2);
   endfunction

   function automatic pwmu_mact_t mact_of(input logic [MACT_W*N_MATCH-1:0] v, input int i);
      return v[MACT_W*i +: MACT_W];
   endfunction

   // Capture input synchroniser, three stages plus a stable copy
   logic [1:0] s1_r, s2_r, s3_r, stb_r;
   logic [1:0] s1_nxt, s2_nxt, s3_nxt, stb_nxt;

   always_comb
   begin
      s1_nxt  = cap_in;
      s2_nxt  = s1_r;
      s3_nxt  = s2_r;
      stb_nxt = stb_r;
      for (int c = 0; c < 2; c++)
      begin
         if (s2_r[c] == s3_r[c])
            stb_nxt[c] = s3_r[c];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         stb_r <= '0;
      end
      else
      begin
         s1_r  <= s1_nxt;
         s2_r  <= s2_nxt;
         s3_r  <= s3_nxt;
         stb_r <= stb_nxt;
      end
   end

   // Software-visible and counting state
   logic [CTRL_W-1:0]         ctrl_r, ctrl_nxt;
   logic [31:0]               tc_r, tc_nxt;
   logic [31:0]               pc_r, pc_nxt;
   logic [31:0]               pr_r, pr_nxt;
   logic [MACT_W*N_MATCH-1:0] mact_r, mact_nxt;
   logic [31:0]               mr_sh_r  [N_MATCH];
   logic [31:0]               mr_sh_nxt[N_MATCH];
   logic [31:0]               mr_r     [N_MATCH];
   logic [31:0]               mr_nxt   [N_MATCH];
   logic [MODE_W-1:0]         mode_r, mode_nxt;
   logic [OCFG_W-1:0]         ocfg_r, ocfg_nxt;
   logic [N_MATCH-1:0]        rel_r, rel_nxt;
   logic [N_MATCH-1:0]        isr_r, isr_nxt;
   logic [N_MATCH-1:0]        imask_r, imask_nxt;
   logic                      irq_r, irq_nxt;

   // Bus request carrier; a write lands only in the answered access cycle
   pwmu_req_t req;
   logic      wr_en;
   logic      pready_r;

   assign req   = '{addr: paddr[7:0], wr: pwrite, wdata: pwdata};
   assign wr_en = psel && penable && req.wr && pready_r && upper_ok(paddr);

   // Count event, prescaler tick and match detection
   logic               pwm_en, run, cnt_ev, step, tick, cyc_start;
   logic               rst_any, stop_any;
   logic [1:0]         chg;
   logic               cap_lvl, cap_chg;
   logic [N_MATCH-1:0] hit;
   pwmu_cmode_t        cmode;

   always_comb
   begin
      pwm_en  = ctrl_r[CTRL_PWM_BIT];
      run     = ctrl_r[CTRL_EN_BIT] && !ctrl_r[CTRL_RST_BIT];
      cmode   = pwmu_cmode_t'(mode_r[MODE_SEL_LSB +: 2]);
      chg     = (s2_r ~^ s3_r) & (s3_r ^ stb_r);
      cap_chg = chg[mode_r[MODE_CAP_BIT]];
      cap_lvl = s3_r[mode_r[MODE_CAP_BIT]];
      unique case (cmode)
         CNT_TIMER: cnt_ev = 1'b1;
         CNT_RISE:  cnt_ev = cap_chg && cap_lvl;
         CNT_FALL:  cnt_ev = cap_chg && !cap_lvl;
         CNT_BOTH:  cnt_ev = cap_chg;
      endcase
      step     = run && cnt_ev;
      tick     = step && (pc_r >= pr_r);                // Lowered limit cannot strand pc
      rst_any  = 1'b0;
      stop_any = 1'b0;
      for (int i = 0; i < N_MATCH; i++)
      begin
         hit[i]   = tick && (tc_r == mr_r[i]);
         rst_any  = rst_any || (hit[i] && mact_of(mact_r, i).rst);
         stop_any = stop_any || (hit[i] && mact_of(mact_r, i).stop);
      end
      // In modulation mode match zero always closes the cycle
      cyc_start = pwm_en && hit[0];
      rst_any   = rst_any || cyc_start;
   end

   // Next state of every register but the counters; hardware sets beat software clears
   always_comb
   begin
      ctrl_nxt  = ctrl_r;
      pr_nxt    = pr_r;
      mact_nxt  = mact_r;
      mode_nxt  = mode_r;
      ocfg_nxt  = ocfg_r;
      imask_nxt = imask_r;
      rel_nxt   = rel_r;
      isr_nxt   = isr_r;
      mr_sh_nxt = mr_sh_r;
      mr_nxt    = mr_r;
      if (wr_en)
      begin
         case (req.addr)
            OFS_CTRL:    ctrl_nxt  = req.wdata[CTRL_W-1:0];
            OFS_PRESC:   pr_nxt    = req.wdata;
            OFS_MACT:    mact_nxt  = req.wdata[MACT_W*N_MATCH-1:0];
            OFS_MODE:    mode_nxt  = req.wdata[MODE_W-1:0];
            OFS_OUTCFG:  ocfg_nxt  = req.wdata[OCFG_W-1:0];
            OFS_IMASK:   imask_nxt = req.wdata[N_MATCH-1:0];
            OFS_ISR:     isr_nxt   = isr_r & ~req.wdata[N_MATCH-1:0];
            default:
            begin
               if (is_mr(req.addr))
                  mr_sh_nxt[mr_idx(req.addr)] = req.wdata;
            end
         endcase
      end
      // A stop action drops the enable even against a same-cycle write
      if (stop_any)
         ctrl_nxt[CTRL_EN_BIT] = 1'b0;
      // Interrupt-flagged matches set status, winning over the clear
      for (int i = 0; i < N_MATCH; i++)
      begin
         if (hit[i] && mact_of(mact_r, i).irq)
            isr_nxt[i] = 1'b1;
         // Shadow copies move to the comparators at once outside modulation, else only when released
         if (!pwm_en)
            mr_nxt[i] = mr_sh_r[i];
         else if (cyc_start && rel_r[i])
         begin
            mr_nxt[i]  = mr_sh_r[i];
            rel_nxt[i] = 1'b0;
         end
      end
      // A release written in the load cycle stays pending for the next one
      if (wr_en && req.addr == OFS_RELEASE)
         rel_nxt = rel_nxt | req.wdata[N_MATCH-1:0];
      irq_nxt = |(isr_r & imask_r);
   end

   // Counter and prescaler
   always_comb
   begin
      tc_nxt = tc_r;
      pc_nxt = pc_r;
      if (ctrl_r[CTRL_RST_BIT])
      begin
         tc_nxt = '0;
         pc_nxt = '0;
      end
      else if (step)
      begin
         pc_nxt = tick ? 32'h0 : pc_r + 32'h1;
         if (tick)
            tc_nxt = rst_any ? 32'h0 : tc_r + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r  <= CTRL_W'(RST_WORD);
         tc_r    <= RST_WORD;
         pc_r    <= RST_WORD;
         pr_r    <= RST_WORD;
         mact_r  <= (MACT_W*N_MATCH)'(RST_WORD);
         mode_r  <= MODE_W'(RST_WORD);
         ocfg_r  <= OCFG_W'(RST_WORD);
         rel_r   <= N_MATCH'(RST_WORD);
         isr_r   <= N_MATCH'(RST_WORD);
         imask_r <= N_MATCH'(RST_WORD);
         irq_r   <= 1'b0;
         for (int i = 0; i < N_MATCH; i++)
         begin
            mr_sh_r[i] <= RST_WORD;
            mr_r[i]    <= RST_WORD;
         end
      end
      else
      begin
         ctrl_r  <= ctrl_nxt;
         tc_r    <= tc_nxt;
         pc_r    <= pc_nxt;
         pr_r    <= pr_nxt;
         mact_r  <= mact_nxt;
         mode_r  <= mode_nxt;
         ocfg_r  <= ocfg_nxt;
         rel_r   <= rel_nxt;
         isr_r   <= isr_nxt;
         imask_r <= imask_nxt;
         irq_r   <= irq_nxt;
         mr_sh_r <= mr_sh_nxt;
         mr_r    <= mr_nxt;
      end
   end

   // Bus answer: data captured in setup so every output is a flop,
   // at the price of one wait-free access cycle per transfer
   logic [31:0] prdata_r, prdata_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic        pready_nxt;
   logic        mapped;

   always_comb
   begin
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      pready_nxt  = psel && !penable;
      mapped      = upper_ok(paddr);
      if (psel && !penable)
      begin
         prdata_nxt = 32'h0;
         case (req.addr)
            OFS_ISR:     prdata_nxt = 32'(isr_r);
            OFS_CTRL:    prdata_nxt = 32'(ctrl_r);
            OFS_COUNT:   prdata_nxt = tc_r;
            OFS_PRESC:   prdata_nxt = pr_r;
            OFS_PCNT:    prdata_nxt = pc_r;
            OFS_MACT:    prdata_nxt = 32'(mact_r);
            OFS_MODE:    prdata_nxt = 32'(mode_r);
            OFS_OUTCFG:  prdata_nxt = 32'(ocfg_r);
            OFS_RELEASE: prdata_nxt = 32'(rel_r);
            OFS_IMASK:   prdata_nxt = 32'(imask_r);
            default:
            begin
               if (is_mr(req.addr))
                  prdata_nxt = mr_sh_r[mr_idx(req.addr)];
               else
                  mapped = 1'b0;
            end
         endcase
         pslverr_nxt = !mapped;
         if (req.wr)
            prdata_nxt = 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= RST_WORD;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // Modulated output stage; output 1 is always single-edge
   pwmu_outgen #(
      .N_OUT (NOUT)
   ) u_outgen (
      .pclk      (pclk),
      .presetn   (presetn),
      .pwm_en    (pwm_en),
      .dbl       (ocfg_r[OCFG_DBL_LSB +: NOUT]),
      .oe        (ocfg_r[OCFG_OE_LSB +: NOUT]),
      .cyc_start (cyc_start),
      .hit       (hit[NOUT:0]),
      .pwm_out   (pwm_out)
   );

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign irq     = irq_r;

endmodule

`default_nettype wire

// ==== test/pwmu_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// Port-level watch of the bus and the modulated outputs
module pwmu_checker
   import pwmu_pkg::*;
#(
   parameter int unsigned N_MATCH = NMATCH
)
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [1:0]        cap_in,
   input wire logic [NOUT-1:0]   pwm_out,
   input wire logic              irq
);
   logic            mode_q;
   logic [NOUT-1:0] oe_q;
   logic [NOUT-1:0] dbl_q;
   logic [NOUT-1:0] sgl;
   logic            wr_ev;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Output 1 is always single-edge, so its select bit does not count
   assign wr_ev = psel && penable && pready && pwrite;
   assign sgl   = oe_q & ~{dbl_q[NOUT-1:1], 1'b0} & {NOUT{mode_q}};
   // Shadow of mode and output set-up, taken from completed writes
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         mode_q <= 1'b0;
         oe_q   <= '0;
         dbl_q  <= '0;
      end
      else if (wr_ev && paddr == {4'h0, OFS_CTRL})
         mode_q <= pwdata[CTRL_PWM_BIT];
      else if (wr_ev && paddr == {4'h0, OFS_OUTCFG})
      begin
         oe_q  <= pwdata[OCFG_OE_LSB +: NOUT];
         dbl_q <= pwdata[OCFG_DBL_LSB +: NOUT];
      end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_settled;
      ($stable(oe_q) && $stable(mode_q) && $stable(dbl_q)) [*3];
   endsequence
   property p_rdy_one;
      s_setup |=> pready;
   endproperty
   a_rdy_one: assert property (p_rdy_one)
      else $error("pready missing after setup");
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse)
      else $error("pready longer than one cycle");
   property p_err_map;
      pready |-> (pslverr == (paddr[11:8] != 4'h0 || paddr[7:0] > OFS_IMASK
         || paddr[1:0] != 2'b00));
   endproperty
   a_err_map: assert property (p_err_map)
      else $error("pslverr does not match address");
   property p_rdata_hold;
      $changed(prdata) |-> $past(psel && !penable);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("prdata moved outside setup");
   property p_mode_off;
      s_settled ##0 !mode_q |-> pwm_out == '0;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("output active without modulation");
   property p_oe_off;
      s_settled |-> (pwm_out & ~oe_q) == '0;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("disabled output not low");
   property p_sgl_rise;
      s_settled ##0 ((pwm_out & ~$past(pwm_out) & sgl) != '0)
         |-> ((pwm_out & sgl) == sgl);
   endproperty
   a_sgl_rise: assert property (p_sgl_rise)
      else $error("single-edge outputs out of step");
   property p_irq_mask;
      wr_ev && paddr == {4'h0, OFS_IMASK} && pwdata[N_MATCH-1:0] == '0
         |-> ##2 (!irq) [*2];
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("irq high with all masked");
endmodule
bind pwmu_top pwmu_checker #(.N_MATCH(N_MATCH)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
   .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

// ==== test/pwmu_load.sv ====
`timescale 1ns/100ps
`default_nettype none
// Load on the modulated pins: high time and period of each, in bus clocks
module pwmu_load
   import pwmu_pkg::*;
(
   input  wire logic [NOUT-1:0] drive,
   input  wire logic            pclk,
   input  wire logic            presetn,
   output var int               hi_w [NOUT],
   output var int               per_w [NOUT]
);
   int              run [NOUT];
   int              age [NOUT];
   logic [NOUT-1:0] prev;
   // Widths latch on the pin edges; a pin that never moves keeps 0
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         prev <= '0;
         run  <= '{default: 0};
         age  <= '{default: 0};
      end
      else
      begin
         prev <= drive;
         for (int k = 0; k < NOUT; k++)
         begin
            run[k] <= drive[k] ? run[k] + 1 : 0;
            age[k] <= (drive[k] && !prev[k]) ? 1 : age[k] + 1;
            if (!drive[k] && prev[k])
               hi_w[k] <= run[k];
            if (drive[k] && !prev[k])
               per_w[k] <= age[k];
         end
      end
endmodule
`default_nettype wire

// ==== test/test_pwm_match_timer_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_pwm_match_timer_unit
   import pwmu_pkg::*;
   ;
   logic            pclk = 1'b0;
   logic            presetn = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [11:0]     paddr = '0;
   logic [31:0]     pwdata = '0;
   logic [1:0]      cap_in = '0;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic [NOUT-1:0] pwm_out;
   logic            irq;
   logic [31:0]     q;
   logic [31:0]     q0;
   logic [1:0]      v;
   logic [1:0]      pv;
   int              hi_w [NOUT];
   int              per_w [NOUT];
   int              m [NMATCH];
   int              err_total = 0;
   int              n_tests = 0;
   int              per = 20;
   int              w;
   int              cnt;
   pwmu_top #(.N_MATCH(NMATCH)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));
   pwmu_load load_u (.drive(pwm_out), .pclk(pclk), .presetn(presetn), .hi_w(hi_w),
      .per_w(per_w));
   always #50 pclk = ~pclk;
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wi, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wi;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 9);
      if (pready !== 1'b1)
      begin
         err_total++;
         stop_test();
      end
      q = prdata;
      q0 = {31'h0, pslverr};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      apb(1'b1, {4'h0, o}, d);
   endtask
   task automatic rdc(input logic [7:0] o, input logic [31:0] e);
      apb(1'b0, {4'h0, o}, 32'h0);
      chk(q, e);
   endtask
   initial
   begin
      void'($urandom(24));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int o = 0; o <= 'h40; o += 4)
         rdc(8'(o), RST_WORD);
      apb(1'b1, 12'h104, 32'h5);
      chk(q0, 32'h1);
      rdc(OFS_CTRL, 32'h0);
      apb(1'b0, 12'h044, 32'h0);
      chk(q0, 32'h1);
      chk(q, 32'h0);
      wr(OFS_COUNT, 32'h1234);
      rdc(OFS_COUNT, 32'h0);
      // Pass 0 all single-edge; pass 1 mixes in three double-edge pins
      for (int c = 0; c < 2; c++)
      begin
         wr(OFS_PRESC, 32'(c));
         wr(OFS_MATCH0, 32'(per - 1));
         for (int i = 1; i < NMATCH; i++)
         begin
            m[i] = 1 + $urandom % (per - 2);
            if (i % 2 == 0 && m[i] == m[i-1])
               m[i] = m[i] % (per - 2) + 1;
            wr(OFS_MATCH0 + 8'(4 * i), 32'(m[i]));
         end
         wr(OFS_RELEASE, 32'h7f);
         wr(OFS_OUTCFG, c ? 32'h3f2a : 32'h3f00);
         wr(OFS_CTRL, 32'h9);
         repeat (4 * per * (c + 1)) @(posedge pclk);
         for (int k = 1; k <= NOUT; k++)
         begin
            w = m[k] - m[k-1] + (m[k] < m[k-1] ? per : 0);
            w = (c && k % 2 == 0) ? w : m[k] + 1;
            chk(hi_w[k-1], w * (c + 1));
            chk(per_w[k-1], per * (c + 1));
         end
      end
      // A new edge stays parked until software releases it
      w = m[1] % (per - 2) + 1;
      wr(OFS_MATCH0 + 8'h4, 32'(w));
      repeat (6 * per) @(posedge pclk);
      chk(hi_w[0], (m[1] + 1) * 2);
      wr(OFS_RELEASE, 32'h2);
      repeat (6 * per) @(posedge pclk);
      rdc(OFS_RELEASE, 32'h0);
      chk(hi_w[0], (w + 1) * 2);
      // Plain timer: match two resets the count and flags, masked first
      wr(OFS_CTRL, 32'h2);
      wr(OFS_PRESC, 32'h0);
      wr(OFS_MATCH0 + 8'h8, 32'h5);
      wr(OFS_MACT, 32'h3 << 6);
      wr(OFS_CTRL, 32'h1);
      repeat (20) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rdc(OFS_ISR, 32'h4);
      repeat (3)
      begin
         apb(1'b0, {4'h0, OFS_COUNT}, 32'h0);
         chk({31'h0, q <= 32'h5}, 32'h1);
      end
      wr(OFS_IMASK, 32'h4);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_MACT, 32'h5 << 6);
      repeat (20) @(posedge pclk);
      rdc(OFS_CTRL, 32'h0);
      apb(1'b0, {4'h0, OFS_COUNT}, 32'h0);
      q0 = q;
      rdc(OFS_COUNT, q0);
      // Masking the pending flag must drop the interrupt line
      wr(OFS_IMASK, 32'h0);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IMASK, 32'h4);
      wr(OFS_ISR, 32'h4);
      rdc(OFS_ISR, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_MACT, 32'h0);
      // Count mode: rising on pin 0, falling on pin 1, then both edges of pin 0; the other is noise
      for (int s = 0; s < 3; s++)
      begin
         cap_in <= 2'b00;
         wr(OFS_MODE, 32'((s + 1) | ((s % 2) << MODE_CAP_BIT)));
         wr(OFS_CTRL, 32'h2);
         wr(OFS_CTRL, 32'h1);
         cnt = 0;
         pv = 2'b00;
         repeat (12)
         begin
            v = 2'($urandom);
            cnt += int'(v[s % 2] != pv[s % 2] && (s == 2 || v[s % 2] == (s == 0)));
            pv = v;
            cap_in <= v;
            repeat (8) @(posedge pclk);
         end
         rdc(OFS_COUNT, 32'(cnt));
      end
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
